// ===== logic/smrs_bank.sv
// How it works
// - a signed blue gain per sequence index 1..128 is kept, limited to -4533..17713, zero by default, color build only.
// - a set is name, equals, value, CR LF and a query is name, question mark, CR LF.
// - the command sequence index is read-write, 1..128, and picks the entry run in command sequence mode.
// - the current command sequence index is read-only: queries answer it, sets are refused.
// - writing 0 to the write-only sequence reset returns both current indices to 1.
// - the sequence table select holds 0 for gamma or 1 for user table, gamma by default.
// - the table select only acts while the per-sequence table enable is true.
// - four roi widths, 16..1936, default 1936.
// - four roi heights, 2..1216, default 1216.
// - four roi horizontal offsets, 0..1920, default 0.
// - four roi vertical offsets, 0..1214, default 0.
// - four row enables, off by default.
// - four column enables, off by default.
module smrs_bank #(
    parameter bit COLOR_MODEL = 1'b1
) (
    input  wire logic                 clk,
    input  wire logic                 arst_n,
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_data,
    output logic                      rx_ready,
    output logic                      rsp_valid,
    output smrs_pkg::smrs_rsp_t       rsp,
    input  wire logic                 trig_seq_step,
    input  wire logic                 cmd_seq_step,
    input  wire logic                 seq_lut_enable,
    output logic [7:0]                cmd_seq_select,
    output logic [7:0]                cmd_seq_current,
    output logic [7:0]                trig_seq_current,
    output logic                      seq_table_select,
    output logic                      use_user_table,
    output logic signed [15:0]        active_blue_gain,
    output smrs_pkg::smrs_roi_t [3:0] roi_cfg,
    output logic [3:0]                roi_row_enable,
    output logic [3:0]                roi_col_enable
);

    // ==========================================================
    // decoding helpers
    function automatic smrs_pkg::smrs_kind_t kind_of(input logic [39:0] nm);
        unique case (nm)
            smrs_pkg::NM_BLUE_GAIN: kind_of = smrs_pkg::K_BLUE;
            smrs_pkg::NM_SEL:       kind_of = smrs_pkg::K_SEL;
            smrs_pkg::NM_CUR:       kind_of = smrs_pkg::K_CUR;
            smrs_pkg::NM_CLEAR:     kind_of = smrs_pkg::K_CLEAR;
            smrs_pkg::NM_TABLE:     kind_of = smrs_pkg::K_TABLE;
            smrs_pkg::NM_WIDTH:     kind_of = smrs_pkg::K_WIDTH;
            smrs_pkg::NM_HEIGHT:    kind_of = smrs_pkg::K_HEIGHT;
            smrs_pkg::NM_HOFF:      kind_of = smrs_pkg::K_HOFF;
            smrs_pkg::NM_VOFF:      kind_of = smrs_pkg::K_VOFF;
            smrs_pkg::NM_ROW:       kind_of = smrs_pkg::K_ROW;
            smrs_pkg::NM_COL:       kind_of = smrs_pkg::K_COL;
            default:                kind_of = smrs_pkg::K_NONE;
        endcase
    endfunction : kind_of

    function automatic logic in_range(input smrs_pkg::smrs_kind_t k, input logic signed [18:0] v);
        logic signed [18:0] lo;
        logic signed [18:0] hi;
        lo = 19'sh0_0000;
        hi = 19'sh0_0001;
        unique case (k)
            smrs_pkg::K_BLUE:   begin lo = smrs_pkg::GAIN_MIN; hi = smrs_pkg::GAIN_MAX; end
            smrs_pkg::K_SEL:    begin lo = 19'(smrs_pkg::SEQ_FIRST); hi = 19'(smrs_pkg::SEQ_LAST); end
            smrs_pkg::K_CLEAR:  hi = 19'sh0_0000;
            smrs_pkg::K_WIDTH:  begin lo = 19'(smrs_pkg::WIDTH_MIN); hi = 19'(smrs_pkg::WIDTH_MAX); end
            smrs_pkg::K_HEIGHT: begin lo = 19'(smrs_pkg::HEIGHT_MIN); hi = 19'(smrs_pkg::HEIGHT_MAX); end
            smrs_pkg::K_HOFF:   hi = 19'(smrs_pkg::HOFF_MAX);
            smrs_pkg::K_VOFF:   hi = 19'(smrs_pkg::VOFF_MAX);
            default:            hi = 19'sh0_0001;
        endcase
        in_range = (v >= lo) && (v <= hi);
    endfunction : in_range

    // ==========================================================
    // parser state
    typedef enum logic [2:0] {S_INIT, S_NAME, S_VAL, S_CR, S_LF, S_SKIP, S_EXEC, S_MEM} smrs_state_t;

    smrs_state_t        state;
    logic [39:0]        name;
    logic [2:0]         name_len;
    logic [7:0]         idx;
    logic               idx_seen;
    logic [16:0]        mag;
    logic               neg;
    logic               dig_seen;
    logic               is_set;
    logic               bad;
    logic [6:0]         init_cnt;

    wire take     = rx_valid && rx_ready;
    wire is_digit = (rx_data >= 8'h30) && (rx_data <= 8'h39);
    wire is_upper = (rx_data >= 8'h41) && (rx_data <= 8'h5A);
    wire [3:0]  digit   = 4'(rx_data - 8'h30);
    wire [11:0] idx_mul = 12'(idx) * 12'h00A + 12'(digit);
    wire [20:0] mag_mul = 21'(mag) * 21'h0_000A + 21'(digit);
    wire [7:0]  next_idx = (idx_mul > 12'h0FF) ? 8'hFF : idx_mul[7:0];
    wire [16:0] next_mag = (mag_mul > 21'h1_FFFF) ? 17'h1_FFFF : mag_mul[16:0];

    assign rx_ready = (state == S_NAME) || (state == S_VAL) || (state == S_CR)
                   || (state == S_LF) || (state == S_SKIP);

    // ==========================================================
    // command check
    wire signed [18:0]    val_pos  = $signed({2'b00, mag});
    wire signed [18:0]    value    = neg ? -val_pos : val_pos;
    wire smrs_pkg::smrs_kind_t kind = kind_of(name);
    wire blue_kind   = (kind == smrs_pkg::K_BLUE);
    wire roi_kind    = (kind >= smrs_pkg::K_WIDTH);
    wire idx_ok      = blue_kind ? (idx >= smrs_pkg::SEQ_FIRST && idx <= smrs_pkg::SEQ_LAST)
                     : roi_kind  ? (idx >= 8'h01 && idx <= 8'(smrs_pkg::ROI_COUNT))
                     : !idx_seen;
    // unknown name, wrong index or a mono build answering a color-only name
    wire name_ok     = (kind != smrs_pkg::K_NONE) && idx_ok && (COLOR_MODEL || !blue_kind);
    wire set_ok      = dig_seen && (kind != smrs_pkg::K_CUR) && in_range(kind, value);
    wire query_ok    = (kind != smrs_pkg::K_CLEAR);
    wire exec_ok     = !bad && name_ok && (is_set ? set_ok : query_ok);
    wire exec        = (state == S_EXEC);
    wire wr          = exec && exec_ok && is_set;
    wire [1:0] ri    = 2'(idx - 8'h01);
    wire [6:0] gi    = 7'(idx - 8'h01);

    // ==========================================================
    // parser
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state    <= S_INIT;
            init_cnt <= 7'h00;
        end else begin
            unique case (state)
                S_INIT: begin
                    init_cnt <= init_cnt + 7'h01;
                    if (init_cnt == 7'h7F) begin
                        state <= S_NAME;
                    end
                end
                S_NAME: if (take) begin
                    if (rx_data == smrs_pkg::CH_EQ)      state <= S_VAL;
                    else if (rx_data == smrs_pkg::CH_QM) state <= S_CR;
                    else if (rx_data == smrs_pkg::CH_LF) state <= S_EXEC;
                    else if (!is_upper && !is_digit)     state <= S_SKIP;
                end
                S_VAL: if (take) begin
                    if (rx_data == smrs_pkg::CH_CR)      state <= S_LF;
                    else if (rx_data == smrs_pkg::CH_LF) state <= S_EXEC;
                    else if (!is_digit && !(rx_data == smrs_pkg::CH_MINUS && !dig_seen && !neg)) state <= S_SKIP;
                end
                S_CR: if (take) begin
                    state <= (rx_data == smrs_pkg::CH_CR) ? S_LF
                           : (rx_data == smrs_pkg::CH_LF) ? S_EXEC : S_SKIP;
                end
                S_LF, S_SKIP: if (take && rx_data == smrs_pkg::CH_LF) begin
                    state <= S_EXEC;
                end else if (take) begin
                    state <= S_SKIP;
                end
                S_EXEC: state <= (!is_set && exec_ok && blue_kind) ? S_MEM : S_NAME;
                S_MEM:  state <= S_NAME;
            endcase
        end
    end

    // malformed framing is remembered and refused at the LF
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            name <= '0; name_len <= 3'h0; idx <= 8'h00; idx_seen <= 1'b0;
            mag <= '0; neg <= 1'b0; dig_seen <= 1'b0; is_set <= 1'b0; bad <= 1'b0;
        end else if (state == S_EXEC) begin
            name <= '0; name_len <= 3'h0; idx <= 8'h00; idx_seen <= 1'b0;
            mag <= '0; neg <= 1'b0; dig_seen <= 1'b0; is_set <= 1'b0; bad <= 1'b0;
        end else if (take) begin
            if (state == S_NAME && is_upper) begin
                name     <= {name[31:0], rx_data};
                name_len <= name_len + 3'h1;
                if (idx_seen || name_len == 3'(smrs_pkg::NAME_MAX)) bad <= 1'b1;
            end else if (state == S_NAME && is_digit) begin
                idx      <= next_idx;
                idx_seen <= 1'b1;
            end else if (state == S_NAME && rx_data == smrs_pkg::CH_EQ) begin
                is_set <= 1'b1;
            end else if (state == S_VAL && is_digit) begin
                mag      <= next_mag;
                dig_seen <= 1'b1;
            end else if (state == S_VAL && rx_data == smrs_pkg::CH_MINUS) begin
                neg <= 1'b1;
            end
            if (state == S_NAME && rx_data == smrs_pkg::CH_LF) bad <= 1'b1;
            if (state == S_LF && rx_data != smrs_pkg::CH_LF) bad <= 1'b1;
            if (state == S_SKIP) bad <= 1'b1;
            if (state == S_CR && rx_data != smrs_pkg::CH_CR) bad <= 1'b1;
            if (state == S_VAL && rx_data == smrs_pkg::CH_LF) bad <= 1'b1;
            if (state == S_VAL && !is_digit && rx_data != smrs_pkg::CH_CR
                && !(rx_data == smrs_pkg::CH_MINUS && !dig_seen && !neg)) bad <= 1'b1;
            if (state == S_NAME && !is_upper && !is_digit && rx_data != smrs_pkg::CH_EQ
                && rx_data != smrs_pkg::CH_QM) bad <= 1'b1;
        end
    end

    // ==========================================================
    // blue gain table, swept to zero after reset
    logic [15:0] gain_rd;
    logic [15:0] gain_act;
    wire  [7:0]  act_idx = (cmd_seq_current == 8'h00) ? 8'h01 : cmd_seq_current;

    smrs_gain_mem #(.DEPTH(smrs_pkg::GAIN_DEPTH), .WIDTH(16), .AW(7)) u_gain (
        .clk     (clk),
        .arst_n  (arst_n),
        .we      ((state == S_INIT) || (wr && blue_kind)),
        .waddr   ((state == S_INIT) ? init_cnt : gi),
        .wdata   ((state == S_INIT) ? 16'h0000 : value[15:0]),
        .raddr_a (gi),
        .rdata_a (gain_rd),
        .raddr_b (7'(act_idx - 8'h01)),
        .rdata_b (gain_act)
    );
    assign active_blue_gain = $signed(gain_act);

    // ==========================================================
    // sequence index and table settings
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_seq_select   <= smrs_pkg::SEQ_DEFAULT;
            seq_table_select <= smrs_pkg::TABLE_GAMMA;
        end else if (wr) begin
            if (kind == smrs_pkg::K_SEL)   cmd_seq_select   <= value[7:0];
            if (kind == smrs_pkg::K_TABLE) seq_table_select <= value[0];
        end
    end

    // the sequence reset wins over a step landing in the same cycle
    wire seq_clear = wr && (kind == smrs_pkg::K_CLEAR);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_seq_current  <= smrs_pkg::SEQ_DEFAULT;
            trig_seq_current <= smrs_pkg::SEQ_DEFAULT;
        end else if (seq_clear) begin
            cmd_seq_current  <= smrs_pkg::SEQ_FIRST;
            trig_seq_current <= smrs_pkg::SEQ_FIRST;
        end else begin
            if (cmd_seq_step) cmd_seq_current <= cmd_seq_select;
            if (trig_seq_step) begin
                trig_seq_current <= (trig_seq_current >= smrs_pkg::SEQ_LAST) ? smrs_pkg::SEQ_FIRST
                                  : trig_seq_current + 8'h01;
            end
        end
    end

    assign use_user_table = seq_lut_enable && (seq_table_select == smrs_pkg::TABLE_USER);

    // ==========================================================
    // roi entries
    for (genvar g = 0; g < smrs_pkg::ROI_COUNT; g++) begin : g_roi
        wire hit = wr && (ri == 2'(g));
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                roi_cfg[g].width   <= smrs_pkg::WIDTH_DEF;
                roi_cfg[g].height  <= smrs_pkg::HEIGHT_DEF;
                roi_cfg[g].hoffset <= smrs_pkg::OFF_DEF;
                roi_cfg[g].voffset <= smrs_pkg::OFF_DEF;
                roi_row_enable[g]  <= 1'b0;
                roi_col_enable[g]  <= 1'b0;
            end else if (hit) begin
                if (kind == smrs_pkg::K_WIDTH)  roi_cfg[g].width   <= value[10:0];
                if (kind == smrs_pkg::K_HEIGHT) roi_cfg[g].height  <= value[10:0];
                if (kind == smrs_pkg::K_HOFF)   roi_cfg[g].hoffset <= value[10:0];
                if (kind == smrs_pkg::K_VOFF)   roi_cfg[g].voffset <= value[10:0];
                if (kind == smrs_pkg::K_ROW)    roi_row_enable[g]  <= value[0];
                if (kind == smrs_pkg::K_COL)    roi_col_enable[g]  <= value[0];
            end
        end
    end

    // ==========================================================
    // answers
    logic [15:0] query_val;
    always_comb begin
        query_val = 16'h0000;
        unique case (kind)
            smrs_pkg::K_SEL:    query_val = 16'(cmd_seq_select);
            smrs_pkg::K_CUR:    query_val = 16'(cmd_seq_current);
            smrs_pkg::K_TABLE:  query_val = 16'(seq_table_select);
            smrs_pkg::K_WIDTH:  query_val = 16'(roi_cfg[ri].width);
            smrs_pkg::K_HEIGHT: query_val = 16'(roi_cfg[ri].height);
            smrs_pkg::K_HOFF:   query_val = 16'(roi_cfg[ri].hoffset);
            smrs_pkg::K_VOFF:   query_val = 16'(roi_cfg[ri].voffset);
            smrs_pkg::K_ROW:    query_val = 16'(roi_row_enable[ri]);
            smrs_pkg::K_COL:    query_val = 16'(roi_col_enable[ri]);
            default:            query_val = 16'h0000;
        endcase
    end

    // gain queries wait one cycle for the table's registered read
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp_valid <= 1'b0;
            rsp       <= '0;
        end else begin
            rsp_valid <= 1'b0;
            if (exec && !(!is_set && exec_ok && blue_kind)) begin
                rsp_valid <= 1'b1;
                rsp.ok    <= exec_ok;
                rsp.value <= (exec_ok && !is_set) ? $signed(query_val) : 16'sh0000;
            end else if (state == S_MEM) begin
                rsp_valid <= 1'b1;
                rsp.ok    <= 1'b1;
                rsp.value <= $signed(gain_rd);
            end
        end
    end

    // ==========================================================
    // checks
    a_line_answered: assert property (@(posedge clk) disable iff (!arst_n)
        (take && rx_data == smrs_pkg::CH_LF) |-> ##[2:3] rsp_valid)
        else $error("line end without an answer");
    a_clear_index: assert property (@(posedge clk) disable iff (!arst_n)
        seq_clear |=> (cmd_seq_current == 8'h01) && (trig_seq_current == 8'h01))
        else $error("sequence reset did not return indices to one");
    a_current_ro: assert property (@(posedge clk) disable iff (!arst_n)
        (exec && is_set && kind == smrs_pkg::K_CUR) |=> rsp_valid && !rsp.ok)
        else $error("set of read-only index accepted");
    a_range_keep: assert property (@(posedge clk) disable iff (!arst_n)
        (exec && is_set && !exec_ok) |=> $stable(roi_cfg) && $stable(cmd_seq_select))
        else $error("refused set changed a setting");
    a_table_gate: assert property (@(posedge clk) disable iff (!arst_n)
        use_user_table |-> seq_lut_enable && seq_table_select)
        else $error("table select acted without enable");
    a_mono_gain: assert property (@(posedge clk) disable iff (!arst_n)
        (exec && blue_kind && !COLOR_MODEL) |=> rsp_valid && !rsp.ok)
        else $error("mono build accepted a gain command");
    a_select_range: assert property (@(posedge clk) disable iff (!arst_n)
        cmd_seq_select <= smrs_pkg::SEQ_LAST)
        else $error("sequence select out of range");
    a_width_range: assert property (@(posedge clk) disable iff (!arst_n)
        roi_cfg[0].width >= smrs_pkg::WIDTH_MIN && roi_cfg[0].width <= smrs_pkg::WIDTH_MAX)
        else $error("roi width out of range");
    a_height_range: assert property (@(posedge clk) disable iff (!arst_n)
        roi_cfg[1].height >= smrs_pkg::HEIGHT_MIN && roi_cfg[1].height <= smrs_pkg::HEIGHT_MAX)
        else $error("roi height out of range");

    c_gain_query: cover property (@(posedge clk) disable iff (!arst_n) state == S_MEM);
    c_clear:      cover property (@(posedge clk) disable iff (!arst_n) seq_clear);
    c_refused:    cover property (@(posedge clk) disable iff (!arst_n) rsp_valid && !rsp.ok);

endmodule : smrs_bank

// ===== logic/smrs_pkg.sv
package smrs_pkg;

    // ==========================================================
    // characters of the command stream
    localparam logic [7:0] CH_CR    = 8'h0D;
    localparam logic [7:0] CH_LF    = 8'h0A;
    localparam logic [7:0] CH_EQ    = 8'h3D;
    localparam logic [7:0] CH_QM    = 8'h3F;
    localparam logic [7:0] CH_MINUS = 8'h2D;

    // ==========================================================
    // parameter names, ascii, right aligned
    localparam logic [39:0] NM_BLUE_GAIN = 40'h53_5150_4742;
    localparam logic [39:0] NM_SEL       = 40'h00_4353_5149;
    localparam logic [39:0] NM_CUR       = 40'h53_5149_4458;
    localparam logic [39:0] NM_CLEAR     = 40'h53_5152_5354;
    localparam logic [39:0] NM_TABLE     = 40'h53_514C_5554;
    localparam logic [39:0] NM_WIDTH     = 40'h00_534D_5257;
    localparam logic [39:0] NM_HEIGHT    = 40'h00_534D_5248;
    localparam logic [39:0] NM_HOFF      = 40'h53_4D52_4F58;
    localparam logic [39:0] NM_VOFF      = 40'h53_4D52_4F59;
    localparam logic [39:0] NM_ROW       = 40'h53_4D52_4F48;
    localparam logic [39:0] NM_COL       = 40'h53_4D52_4F56;
    localparam int          NAME_MAX     = 5;

    // ==========================================================
    // ranges and defaults
    localparam logic signed [18:0] GAIN_MIN   = -19'sh0_11B5;
    localparam logic signed [18:0] GAIN_MAX   = 19'sh0_4531;
    localparam logic [7:0]  SEQ_FIRST   = 8'h01;
    localparam logic [7:0]  SEQ_LAST    = 8'h80;
    localparam logic [7:0]  SEQ_DEFAULT = 8'h00;
    localparam logic [10:0] WIDTH_MIN   = 11'h010;
    localparam logic [10:0] WIDTH_MAX   = 11'h790;
    localparam logic [10:0] HEIGHT_MIN  = 11'h002;
    localparam logic [10:0] HEIGHT_MAX  = 11'h4C0;
    localparam logic [10:0] HOFF_MAX    = 11'h780;
    localparam logic [10:0] VOFF_MAX    = 11'h4BE;
    localparam logic [10:0] WIDTH_DEF   = 11'h790;
    localparam logic [10:0] HEIGHT_DEF  = 11'h4C0;
    localparam logic [10:0] OFF_DEF     = 11'h000;
    localparam logic        TABLE_GAMMA = 1'b0;
    localparam logic        TABLE_USER  = 1'b1;
    localparam int          ROI_COUNT   = 4;
    localparam int          GAIN_DEPTH  = 128;

    // ==========================================================
    // types
    typedef enum logic [3:0] {
        K_NONE, K_BLUE, K_SEL, K_CUR, K_CLEAR, K_TABLE,
        K_WIDTH, K_HEIGHT, K_HOFF, K_VOFF, K_ROW, K_COL
    } smrs_kind_t;

    typedef struct packed {
        logic [10:0] width;
        logic [10:0] height;
        logic [10:0] hoffset;
        logic [10:0] voffset;
    } smrs_roi_t;

    typedef struct packed {
        logic               ok;
        logic signed [15:0] value;
    } smrs_rsp_t;

endpackage : smrs_pkg

// ===== logic/smrs_gain_mem.sv
module smrs_gain_mem #(
    parameter int DEPTH = 128,
    parameter int WIDTH = 16,
    parameter int AW    = 7
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [AW-1:0]    raddr_a,
    output logic      [WIDTH-1:0] rdata_a,
    input  wire logic [AW-1:0]    raddr_b,
    output logic      [WIDTH-1:0] rdata_b
);

    // ==========================================================
    // storage, no reset: the owner sweeps it clear after reset
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end

endmodule : smrs_gain_mem

// ===== verification/testbench.sv
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
// ====================
// command stream bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [39:0] nm; string tx; logic ok; logic [15:0] v;} smrs_row_t;
    logic clk = 0, arst_n = 0, rx_valid = 0, trig_seq_step = 0, cmd_seq_step = 0, seq_lut_enable = 0;
    logic rx_ready, rsp_valid, seq_table_select, use_user_table;
    logic [7:0] rx_data = 8'h00, cmd_seq_select, cmd_seq_current, trig_seq_current;
    logic signed [15:0] active_blue_gain;
    smrs_pkg::smrs_rsp_t rsp, mono_rsp;
    smrs_pkg::smrs_roi_t [3:0] roi_cfg;
    logic [3:0] roi_row_enable, roi_col_enable;
    int mismatches = 0, n_tests = 0;
    smrs_row_t rows [] = '{
        '{smrs_pkg::NM_WIDTH, "2=16", 1, 16'h0},
        '{smrs_pkg::NM_WIDTH, "2=15", 0, 16'h0},
        '{smrs_pkg::NM_WIDTH, "2?", 1, 16'h0010},
        '{smrs_pkg::NM_HEIGHT, "4=1217", 0, 16'h0},
        '{smrs_pkg::NM_HEIGHT, "4?", 1, 16'h04C0},
        '{smrs_pkg::NM_HOFF, "1=1920", 1, 16'h0},
        '{smrs_pkg::NM_VOFF, "3=1215", 0, 16'h0},
        '{smrs_pkg::NM_ROW, "4=1", 1, 16'h0},
        '{smrs_pkg::NM_COL, "1=2", 0, 16'h0},
        '{smrs_pkg::NM_COL, "1=1", 1, 16'h0},
        '{smrs_pkg::NM_BLUE_GAIN, "128=-4533", 1, 16'h0},
        '{smrs_pkg::NM_BLUE_GAIN, "128?", 1, 16'hEE4B},
        '{smrs_pkg::NM_SEL, "=128", 1, 16'h0},
        '{smrs_pkg::NM_CUR, "=1", 0, 16'h0},
        '{smrs_pkg::NM_TABLE, "=1", 1, 16'h0},
        '{smrs_pkg::NM_CLEAR, "?", 0, 16'h0}};
    always #12.5 clk = ~clk;
    smrs_bank dut (.clk, .arst_n, .rx_valid, .rx_data, .rx_ready, .rsp_valid, .rsp, .trig_seq_step,
        .cmd_seq_step, .seq_lut_enable, .cmd_seq_select, .cmd_seq_current, .trig_seq_current,
        .seq_table_select, .use_user_table, .active_blue_gain, .roi_cfg, .roi_row_enable, .roi_col_enable);
    // mono build shares the stream; it never needs the extra table cycle, so it is ready whenever dut is
    smrs_bank #(.COLOR_MODEL(1'b0)) dut_mono (.clk, .arst_n, .rx_valid, .rx_data, .rx_ready(), .rsp_valid(),
        .rsp(mono_rsp), .trig_seq_step, .cmd_seq_step, .seq_lut_enable, .cmd_seq_select(), .cmd_seq_current(),
        .trig_seq_current(), .seq_table_select(), .use_user_table(), .active_blue_gain(), .roi_cfg(),
        .roi_row_enable(), .roi_col_enable());
    task report_and_stop;
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : report_and_stop
    task put(input logic [7:0] c);
        int i;
        @(negedge clk);
        rx_valid = 1;
        rx_data = c;
        i = 0;
        // ready depends on state only, so a settled look at the falling edge predicts the take
        // long bound covers the table sweep after reset
        while (rx_ready !== 1'b1 && i < 300) begin @(negedge clk); i++; end
        if (rx_ready !== 1'b1) begin mismatches++; report_and_stop(); end
        @(posedge clk);
    endtask : put
    task line(input logic [39:0] nm, input string tx, input logic ok, input logic [15:0] v);
        int i;
        for (i = 4; i >= 0; i--) if (nm[i*8+:8] != 8'h00) put(nm[i*8+:8]);
        for (i = 0; i < tx.len(); i++) put(tx[i]);
        put(smrs_pkg::CH_CR);
        put(smrs_pkg::CH_LF);
        @(negedge clk);
        rx_valid = 0;
        i = 0;
        while (rsp_valid !== 1'b1 && i < 8) begin @(negedge clk); i++; end
        if (rsp_valid !== 1'b1) begin mismatches++; report_and_stop(); end
        `CHK(rsp.ok, ok)
        `CHK(rsp.value, v)
    endtask : line
    initial begin
        repeat (2) @(negedge clk);
        arst_n = 1;
        foreach (rows[k]) line(rows[k].nm, rows[k].tx, rows[k].ok, rows[k].v);
        line(smrs_pkg::NM_BLUE_GAIN, "1?", 1, 16'h0);
        `CHK(mono_rsp.ok, 1'b0)
        `CHK(roi_col_enable, 4'h1)
        `CHK(roi_cfg[0].hoffset, smrs_pkg::HOFF_MAX)
        `CHK(roi_row_enable, 4'h8)
        `CHK(seq_table_select, smrs_pkg::TABLE_USER)
        `CHK(use_user_table, 1'b0)
        seq_lut_enable = 1;
        trig_seq_step = 1;
        cmd_seq_step = 1;
        @(negedge clk);
        trig_seq_step = 0;
        cmd_seq_step = 0;
        @(negedge clk);
        `CHK(use_user_table, 1'b1)
        `CHK(cmd_seq_current, 8'h80)
        `CHK(active_blue_gain, 16'hEE4B)
        line(smrs_pkg::NM_CUR, "?", 1, 16'h0080);
        line(smrs_pkg::NM_CLEAR, "=0", 1, 16'h0);
        `CHK(cmd_seq_current, 8'h01)
        `CHK(trig_seq_current, 8'h01)
        arst_n = 0;
        @(negedge clk);
        `CHK(roi_cfg[1].width, smrs_pkg::WIDTH_DEF)
        `CHK(roi_row_enable, 4'h0)
        `CHK(cmd_seq_select, smrs_pkg::SEQ_DEFAULT)
        `CHK(rx_ready, 1'b0)
        arst_n = 1;
        line(smrs_pkg::NM_WIDTH, "2?", 1, 16'h0790);
        report_and_stop();
    end
endmodule : testbench
